// ---- msi_decode_pkg.sv ----
// Shared constants and types for the message interrupt data decoder
package msi_decode_pkg;

    // Address word layout
    localparam logic [11:0] ADDR_WINDOW = 12'hFEE;
    localparam int ADDR_WIN_MSB = 31;
    localparam int ADDR_WIN_LSB = 20;
    localparam int ADDR_DEST_MSB = 19;
    localparam int ADDR_DEST_LSB = 12;
    localparam int ADDR_RH_BIT = 3;
    localparam int ADDR_DM_BIT = 2;

    // Data word layout
    localparam int DATA_VEC_MSB = 7;
    localparam int DATA_VEC_LSB = 0;
    localparam int DATA_MODE_MSB = 10;
    localparam int DATA_MODE_LSB = 8;
    localparam int DATA_LEVEL_BIT = 14;
    localparam int DATA_TRIG_BIT = 15;

    // Vector limits and special identifiers
    localparam logic [7:0] VEC_MIN = 8'h10;
    localparam logic [7:0] VEC_MAX = 8'hFE;
    localparam logic [7:0] BCAST_ID = 8'hFF;

    // Reset values
    localparam logic [31:0] PAYLOAD_RESET = 32'h0000_0000;

    // Default processor count
    localparam int NUM_CPUS_DEFAULT = 8;

    typedef enum logic [2:0] {
        dlv_fixed = 3'b000,
        dlv_lowest = 3'b001,
        dlv_sys_mgmt_irq_mode = 3'b010,
        dlv_rsvd_3 = 3'b011,
        dlv_nmi = 3'b100,
        dlv_init = 3'b101,
        dlv_rsvd_6 = 3'b110,
        dlv_legacy_external_irq_mode = 3'b111
    } delivery_mode_t;

    typedef struct packed {
        logic valid;
        logic [31:0] addr;
        logic [31:0] data;
    } msg_write_t;

    typedef struct packed {
        logic [7:0] dest_id;
        logic redirect_hint;
        logic dest_addr_kind;
        logic lowest_pri;
        logic [7:0] vector;
        logic vector_valid;
        delivery_mode_t mode;
        logic level_trig;
        logic assert_msg;
        logic legacy_irq_input;
    } irq_req_t;

    typedef struct packed {
        logic rsvd_mode;
        logic low_vector;
    } msg_fault_t;

endpackage : msi_decode_pkg

// ---- msg_payload_reg.sv ----
// Holding register for the last accepted message data word
`timescale 1ns/100ps

module msg_payload_reg (
    // Clock and reset
    input wire logic clk,
    input wire logic srst,
    // Write side
    input wire logic wr_en,
    input wire logic [31:0] wr_data,
    // Read side
    output logic [31:0] rd_data
);

    logic [31:0] payload_q;

    // Whole word kept, reserved bits included, never interpreted here
    always_ff @(posedge clk) begin
        if (srst) begin
            payload_q <= msi_decode_pkg::PAYLOAD_RESET;
        end else if (wr_en) begin
            payload_q <= wr_data;
        end
    end

    assign rd_data = payload_q;

endmodule : msg_payload_reg

// ---- msi_message_data_decoder.sv ----
// Decoder and checker for message signalled interrupt writes
//
// Function
// - Vector is eight bits, 10h to FEh; the code faults only vectors below 10h, FFh passes
// - Code 000 delivers to all destinations
// - Code 001 picks lowest priority destination; the code only sets lowest_pri, and target_mask keeps every matching processor
// - Code 010 is edge-only system management
// - Code 100 NMI, edge, vector ignored
// - Code 101 INIT, edge, vector ignored
// - Code 111 legacy input, edge, acknowledged vector
// - Edge messages are always assertions
// - Level messages carry the input level
// - Trigger bit zero edge, one level
// - Accept only address window FEEh
// - Destination identifier selects target processors
// - Hint clear delivers to named processor
// - Hint set lets mode bit choose matching
`timescale 1ns/100ps

module msi_message_data_decoder #(
    parameter int NUM_CPUS = msi_decode_pkg::NUM_CPUS_DEFAULT
) (
    // Clock and reset
    input wire logic clk,
    input wire logic srst,
    // Incoming DWORD message write
    input wire msi_decode_pkg::msg_write_t msg_in,
    // Identifiers of the attached processors
    input wire logic [NUM_CPUS-1:0][7:0] cpu_phys_id,
    input wire logic [NUM_CPUS-1:0][7:0] cpu_logic_id,
    // Decoded delivery request
    output logic req_valid,
    output msi_decode_pkg::irq_req_t req,
    output logic [NUM_CPUS-1:0] target_mask,
    // Malformed message report
    output logic fault_valid,
    output msi_decode_pkg::msg_fault_t fault,
    // Last accepted data word
    output logic [31:0] payload_rd
);

    // Modes whose vector field is meaningful
    function automatic logic vector_required(input msi_decode_pkg::delivery_mode_t m);
        return (m == msi_decode_pkg::dlv_fixed) || (m == msi_decode_pkg::dlv_lowest);
    endfunction : vector_required

    // Modes that may be level triggered
    function automatic logic level_allowed(input msi_decode_pkg::delivery_mode_t m);
        return (m == msi_decode_pkg::dlv_fixed) || (m == msi_decode_pkg::dlv_lowest);
    endfunction : level_allowed

    // Field extraction
    logic win_hit;
    logic [7:0] dest_id;
    logic rh_bit;
    logic dm_bit;
    logic [7:0] vec_field;
    msi_decode_pkg::delivery_mode_t mode_field;
    logic level_bit;
    logic trig_bit;

    assign win_hit = msg_in.valid &&
        (msg_in.addr[msi_decode_pkg::ADDR_WIN_MSB:msi_decode_pkg::ADDR_WIN_LSB] == msi_decode_pkg::ADDR_WINDOW);
    assign dest_id = msg_in.addr[msi_decode_pkg::ADDR_DEST_MSB:msi_decode_pkg::ADDR_DEST_LSB];
    assign rh_bit = msg_in.addr[msi_decode_pkg::ADDR_RH_BIT];
    assign dm_bit = msg_in.addr[msi_decode_pkg::ADDR_DM_BIT];
    // Only defined fields are sliced; reserved positions are never looked at
    assign vec_field = msg_in.data[msi_decode_pkg::DATA_VEC_MSB:msi_decode_pkg::DATA_VEC_LSB];
    assign mode_field = msi_decode_pkg::delivery_mode_t'(
        msg_in.data[msi_decode_pkg::DATA_MODE_MSB:msi_decode_pkg::DATA_MODE_LSB]);
    assign level_bit = msg_in.data[msi_decode_pkg::DATA_LEVEL_BIT];
    assign trig_bit = msg_in.data[msi_decode_pkg::DATA_TRIG_BIT];

    // Mode classification
    logic rsvd_mode;
    logic low_vector;
    logic bad_msg;
    logic level_trig_d;
    logic assert_d;
    logic legacy_d;
    logic lowest_d;

    always_comb begin
        rsvd_mode = 1'b0;
        legacy_d = 1'b0;
        lowest_d = 1'b0;
        unique case (mode_field)
            msi_decode_pkg::dlv_fixed: begin
                lowest_d = 1'b0;
            end
            msi_decode_pkg::dlv_lowest: begin
                lowest_d = 1'b1;
            end
            msi_decode_pkg::dlv_sys_mgmt_irq_mode: begin
                lowest_d = 1'b0;
            end
            msi_decode_pkg::dlv_nmi: begin
                lowest_d = 1'b0;
            end
            msi_decode_pkg::dlv_init: begin
                lowest_d = 1'b0;
            end
            msi_decode_pkg::dlv_legacy_external_irq_mode: begin
                legacy_d = 1'b1;
            end
            msi_decode_pkg::dlv_rsvd_3,
            msi_decode_pkg::dlv_rsvd_6: begin
                rsvd_mode = 1'b1;
            end
        endcase
    end

    // Low vectors are only a fault where the vector is used; pairing is trusted
    assign low_vector = vector_required(mode_field) && (vec_field < msi_decode_pkg::VEC_MIN);
    assign bad_msg = rsvd_mode || low_vector;
    // Edge-only modes force edge whatever the trigger bit holds
    assign level_trig_d = trig_bit && level_allowed(mode_field);
    // Edge messages are assertions; level messages follow the input level
    assign assert_d = level_trig_d ? level_bit : 1'b1;

    // Destination matching per processor
    logic [NUM_CPUS-1:0] mask_d;

    generate
        for (genvar i = 0; i < NUM_CPUS; i++) begin : g_match
            logic phys_hit;
            logic log_hit;
            assign phys_hit = (cpu_phys_id[i] == dest_id) || (dest_id == msi_decode_pkg::BCAST_ID);
            assign log_hit = |(cpu_logic_id[i] & dest_id);
            // Hint clear ignores the mode bit and uses the named processor
            assign mask_d[i] = (rh_bit && dm_bit) ? log_hit : phys_hit;
        end
    endgenerate

    // Request strobe, one cycle per accepted write that raises no fault
    logic req_valid_q;

    always_ff @(posedge clk) begin
        if (srst) begin
            req_valid_q <= 1'b0;
        end else begin
            req_valid_q <= win_hit && !bad_msg;
        end
    end

    // Request contents
    msi_decode_pkg::irq_req_t req_q;
    logic [NUM_CPUS-1:0] target_mask_q;

    always_ff @(posedge clk) begin
        if (srst) begin
            req_q <= '0;
            target_mask_q <= '0;
        end else if (win_hit && !bad_msg) begin
            req_q.dest_id <= dest_id;
            req_q.redirect_hint <= rh_bit;
            req_q.dest_addr_kind <= dm_bit;
            req_q.lowest_pri <= lowest_d;
            req_q.vector <= vec_field;
            req_q.vector_valid <= vector_required(mode_field);
            req_q.mode <= mode_field;
            req_q.level_trig <= level_trig_d;
            req_q.assert_msg <= assert_d;
            req_q.legacy_irq_input <= legacy_d;
            target_mask_q <= mask_d;
        end
    end

    // Fault report
    logic fault_valid_q;
    msi_decode_pkg::msg_fault_t fault_q;

    always_ff @(posedge clk) begin
        if (srst) begin
            fault_valid_q <= 1'b0;
            fault_q <= '0;
        end else begin
            fault_valid_q <= win_hit && bad_msg;
            if (win_hit && bad_msg) begin
                fault_q.rsvd_mode <= rsvd_mode;
                fault_q.low_vector <= low_vector;
            end
        end
    end

    // Payload holding register
    msg_payload_reg u_payload (
        .clk(clk),
        .srst(srst),
        .wr_en(win_hit),
        .wr_data(msg_in.data),
        .rd_data(payload_rd)
    );

    assign req_valid = req_valid_q;
    assign req = req_q;
    assign target_mask = target_mask_q;
    assign fault_valid = fault_valid_q;
    assign fault = fault_q;

    // Checks
    sequence s_hit_mode(msi_decode_pkg::delivery_mode_t m);
        win_hit && (mode_field == m);
    endsequence

    sequence s_good_hit;
        win_hit && !rsvd_mode && !low_vector;
    endsequence

    property p_window_only;
        @(posedge clk) disable iff (srst)
        (msg_in.valid && !win_hit) |=> (!req_valid && !fault_valid);
    endproperty
    a_window_only: assert property (p_window_only) else $error("write outside window produced output");

    property p_one_request;
        @(posedge clk) disable iff (srst)
        req_valid |-> ($past(win_hit) && !fault_valid);
    endproperty
    a_one_request: assert property (p_one_request) else $error("request without accepted write");

    property p_good_delivers;
        @(posedge clk) disable iff (srst)
        s_good_hit |=> req_valid;
    endproperty
    a_good_delivers: assert property (p_good_delivers) else $error("accepted write gave no request");

    property p_rsvd_flag;
        @(posedge clk) disable iff (srst)
        (s_hit_mode(msi_decode_pkg::dlv_rsvd_3) or s_hit_mode(msi_decode_pkg::dlv_rsvd_6))
            |=> (fault_valid && fault.rsvd_mode && !req_valid);
    endproperty
    a_rsvd_flag: assert property (p_rsvd_flag) else $error("reserved delivery code not flagged");

    property p_low_vector;
        @(posedge clk) disable iff (srst)
        (win_hit && vector_required(mode_field) && (vec_field <= 8'h0F))
            |=> (fault_valid && fault.low_vector && !req_valid);
    endproperty
    a_low_vector: assert property (p_low_vector) else $error("forbidden vector delivered");

    property p_vector_range;
        @(posedge clk) disable iff (srst)
        (req_valid && req.vector_valid) |-> (req.vector >= msi_decode_pkg::VEC_MIN && req.vector <= msi_decode_pkg::VEC_MAX);
    endproperty
    a_vector_range: assert property (p_vector_range) else $error("vector below legal range");

    property p_edge_only;
        @(posedge clk) disable iff (srst)
        (req_valid && !level_allowed(req.mode)) |-> (!req.level_trig && req.assert_msg && !req.vector_valid);
    endproperty
    a_edge_only: assert property (p_edge_only) else $error("edge-only mode not forced to edge");

    property p_edge_assert;
        @(posedge clk) disable iff (srst)
        (req_valid && !req.level_trig) |-> req.assert_msg;
    endproperty
    a_edge_assert: assert property (p_edge_assert) else $error("edge message not an assertion");

    property p_level_follows;
        @(posedge clk) disable iff (srst)
        (s_hit_mode(msi_decode_pkg::dlv_fixed) && !low_vector && trig_bit)
            |=> (req.level_trig && (req.assert_msg == $past(level_bit)));
    endproperty
    a_level_follows: assert property (p_level_follows) else $error("level message lost input state");

    property p_legacy;
        @(posedge clk) disable iff (srst)
        s_hit_mode(msi_decode_pkg::dlv_legacy_external_irq_mode)
            |=> (req_valid && req.legacy_irq_input && !req.level_trig);
    endproperty
    a_legacy: assert property (p_legacy) else $error("legacy mode not routed to legacy input");

    property p_lowest;
        @(posedge clk) disable iff (srst)
        req_valid |-> (req.lowest_pri == (req.mode == msi_decode_pkg::dlv_lowest));
    endproperty
    a_lowest: assert property (p_lowest) else $error("lowest priority flag wrong");

    property p_payload;
        @(posedge clk) disable iff (srst)
        win_hit |=> (payload_rd == $past(msg_in.data));
    endproperty
    a_payload: assert property (p_payload) else $error("payload word not held");

    property p_req_hold;
        @(posedge clk) disable iff (srst)
        (!srst && !(win_hit && !bad_msg)) |=> ($stable(req) && $stable(target_mask) && !req_valid);
    endproperty
    a_req_hold: assert property (p_req_hold) else $error("request changed without accepted write");

    property p_payload_hold;
        @(posedge clk) disable iff (srst)
        (!srst && !win_hit) |=> $stable(payload_rd);
    endproperty
    a_payload_hold: assert property (p_payload_hold) else $error("payload changed outside window");

endmodule : msi_message_data_decoder

// ---- msi_writer.sv ----
// Partner model: the function that sends message writes
`timescale 1ns/100ps

module msi_writer (
    // Clock
    input wire logic clk,
    // Message write
    output msi_decode_pkg::msg_write_t msg
);
    // Reserved data bits 31:16 and 13:11 as the writer found them
    localparam logic [31:0] RSVD_KEEP = 32'h5A5A_2800;

    initial begin
        msg = '0;
    end

    // Builds a data word, keeping the reserved bits intact
    function automatic logic [31:0] mk(input logic [7:0] vec, input logic [2:0] mode, input logic lvl,
                                       input logic trig);
        mk = RSVD_KEEP | {16'h0000, trig, lvl, 3'h0, mode, vec};
    endfunction : mk

    // One DWORD write, valid one cycle; afterwards the lines show the inverse
    task automatic send(input logic [31:0] a, input logic [31:0] d);
        @(posedge clk);
        msg <= '{valid: 1'b1, addr: a, data: d};
        @(posedge clk);
        msg <= '{valid: 1'b0, addr: ~a, data: ~d};
    endtask : send
endmodule : msi_writer

// ---- tb.sv ----
// Self-checking testbench for the message interrupt data decoder
`timescale 1ns/100ps
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin errors++; \
    $display("CHECK FAILED t=%0t got=%0h exp=%0h", $time, (a), (b)); end end

module tb;
    logic clk;
    logic srst;
    msi_decode_pkg::msg_write_t msg;
    logic [7:0][7:0] phys_id;
    logic [7:0][7:0] logic_id;
    logic req_valid;
    msi_decode_pkg::irq_req_t req;
    logic [7:0] target_mask;
    logic fault_valid;
    msi_decode_pkg::msg_fault_t fault;
    logic [31:0] payload_rd;
    int errors = 0;
    int check_count = 0;
    int cycles = 0;

    msi_writer u_wr (.clk(clk), .msg(msg));

    msi_message_data_decoder #(.NUM_CPUS(8)) u_dut (
        .clk(clk), .srst(srst), .msg_in(msg), .cpu_phys_id(phys_id), .cpu_logic_id(logic_id),
        .req_valid(req_valid), .req(req), .target_mask(target_mask), .fault_valid(fault_valid),
        .fault(fault), .payload_rd(payload_rd)
    );

    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    always @(posedge clk) begin
        cycles++;
        if (cycles == 5000) begin
            errors++;
            tally_and_finish();
        end
    end

    task automatic tally_and_finish();
        $display("errors=%0d check_count=%0d", errors, check_count);
        if (errors == 0 && check_count > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : tally_and_finish

    // Pulses right after the taking edge, gone after the next edge
    task automatic answer(input logic rv, input logic fv);
        #1;
        `CHK(req_valid, rv)
        `CHK(fault_valid, fv)
        @(posedge clk);
        #1;
        `CHK(req_valid, 1'b0)
        `CHK(fault_valid, 1'b0)
    endtask : answer

    task automatic t_trigger();
        logic [31:0] d;
        d = u_wr.mk(8'h30, 3'd0, 1'b0, 1'b1);
        u_wr.send(32'hFEE0_1000, d);
        answer(1'b1, 1'b0);
        `CHK(req.vector, 8'h30)
        `CHK(req.vector_valid, 1'b1)
        `CHK({req.level_trig, req.assert_msg}, 2'b10)
        `CHK(target_mask, 8'h02)
        `CHK(payload_rd, d)
        u_wr.send(32'hFEE0_1000, u_wr.mk(8'h30, 3'd0, 1'b1, 1'b1));
        answer(1'b1, 1'b0);
        `CHK({req.level_trig, req.assert_msg}, 2'b11)
        u_wr.send(32'hFEE0_1000, u_wr.mk(8'hFE, 3'd0, 1'b0, 1'b0));
        answer(1'b1, 1'b0);
        `CHK(req.vector, 8'hFE)
        `CHK({req.level_trig, req.assert_msg}, 2'b01)
    endtask : t_trigger

    task automatic t_modes();
        logic [2:0] codes [6] = '{3'd0, 3'd1, 3'd2, 3'd4, 3'd5, 3'd7};
        logic [2:0] c;
        logic vb;
        for (int i = 0; i < 6; i++) begin
            c = codes[i];
            vb = (c < 3'd2);
            u_wr.send(32'hFEE_FF000, u_wr.mk((c == 3'd2) ? 8'h00 : 8'h40, c, 1'b0,
                                             vb | (c == 3'd4) | (c == 3'd5)));
            answer(1'b1, 1'b0);
            `CHK(req.mode, msi_decode_pkg::delivery_mode_t'(c))
            `CHK(req.vector_valid, vb)
            `CHK({req.level_trig, req.assert_msg}, {vb, ~vb})
            `CHK(req.lowest_pri, (c == 3'd1))
            `CHK(req.legacy_irq_input, (c == 3'd7))
            `CHK(target_mask, 8'hFF)
        end
    endtask : t_modes

    task automatic t_faults();
        logic [31:0] p;
        u_wr.send(32'hFEE0_1000, u_wr.mk(8'h05, 3'd3, 1'b0, 1'b0));
        answer(1'b0, 1'b1);
        `CHK(fault, 2'b10)
        u_wr.send(32'hFEE0_1000, u_wr.mk(8'h40, 3'd6, 1'b0, 1'b0));
        answer(1'b0, 1'b1);
        `CHK(fault.rsvd_mode, 1'b1)
        u_wr.send(32'hFEE0_1000, u_wr.mk(8'h0F, 3'd0, 1'b0, 1'b0));
        answer(1'b0, 1'b1);
        `CHK(fault, 2'b01)
        u_wr.send(32'hFEE0_1000, u_wr.mk(8'h10, 3'd1, 1'b0, 1'b0));
        answer(1'b1, 1'b0);
        `CHK(req.vector, 8'h10)
        p = payload_rd;
        u_wr.send(32'hFED0_1000, u_wr.mk(8'h50, 3'd0, 1'b0, 1'b0));
        answer(1'b0, 1'b0);
        `CHK(payload_rd, p)
    endtask : t_faults

    task automatic t_dest();
        u_wr.send(32'hFEE0_3004, u_wr.mk(8'h40, 3'd0, 1'b0, 1'b0));
        answer(1'b1, 1'b0);
        `CHK(target_mask, 8'h08)
        `CHK(req.dest_id, 8'h03)
        u_wr.send(32'hFEE0_3008, u_wr.mk(8'h40, 3'd1, 1'b0, 1'b0));
        answer(1'b1, 1'b0);
        `CHK(target_mask, 8'h08)
        u_wr.send(32'hFEE0_600C, u_wr.mk(8'h40, 3'd1, 1'b0, 1'b0));
        answer(1'b1, 1'b0);
        `CHK(target_mask, 8'h06)
        `CHK({req.redirect_hint, req.dest_addr_kind}, 2'b11)
    endtask : t_dest

    task automatic t_reset();
        @(posedge clk);
        srst <= 1'b1;
        @(posedge clk);
        srst <= 1'b0;
        #1;
        `CHK(payload_rd, 32'h0000_0000)
        `CHK(target_mask, 8'h00)
        `CHK({req_valid, fault_valid, fault, req.vector}, 12'h000)
    endtask : t_reset

    initial begin
        srst = 1'b1;
        for (int i = 0; i < 8; i++) begin
            phys_id[i] = 8'(i);
            logic_id[i] = 8'h01 << i;
        end
        repeat (6) @(posedge clk);
        srst <= 1'b0;
        t_trigger();
        t_modes();
        t_faults();
        t_dest();
        t_reset();
        t_trigger();
        tally_and_finish();
    end
endmodule : tb
